//--- logic/isl_intr_status.sv
`timescale 1ns/10ps
module isl_intr_status
(
    input  wire logic                          CORE_CLK,
    input  wire logic                          RESET_N,
    input  wire isl_pkg::isl_ev_t              EVENTS,
    input  wire logic [isl_pkg::ABRT_W-1:0]    ABORT_CAUSE,
    input  wire isl_pkg::isl_clr_t             CLEAR_RD,
    input  wire logic                          CTRL_ENABLE,
    input  wire logic                          ENABLE_INTERNAL,
    input  wire logic                          FSM_ACTIVE,
    input  wire logic [isl_pkg::LVL_W-1:0]     TX_LEVEL,
    input  wire logic [isl_pkg::LVL_W-1:0]     TX_THRESHOLD,
    input  wire logic [isl_pkg::LVL_W-1:0]     RX_LEVEL,
    input  wire logic [isl_pkg::LVL_W-1:0]     RX_THRESHOLD,
    input  wire logic                          DCMD_WRITE,
    input  wire logic                          DCMD_READ,
    input  wire isl_pkg::isl_stat_t            INTR_MASK,
    input  wire logic                          RX_BYTE_VALID,
    output      logic                          RX_BYTE_READY,
    input  wire logic [isl_pkg::BYTE_W-1:0]    RX_BYTE_DATA,
    output      logic                          RXF_VALID,
    input  wire logic                          RXF_READY,
    output      logic [isl_pkg::BYTE_W-1:0]    RXF_DATA,
    output      isl_pkg::isl_stat_t            INTR_STATUS,
    output      isl_pkg::isl_stat_t            RAW_STATUS,
    output      logic [isl_pkg::ABRT_W-1:0]    ABORT_REASON,
    output      logic                          TX_FLUSH,
    output      logic                          TX_ACCEPT,
    output      logic                          RX_FLUSH,
    output      logic                          SCL_HOLD_LOW
);
    import isl_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    // set has priority so an event in the clear cycle survives
    function automatic logic sticky(input logic set, input logic clr, input logic q);
        sticky = set | (q & ~clr);
    endfunction

    function automatic logic is_full(input logic [LVL_W-1:0] lvl);
        is_full = (lvl == LVL_W'(FIFO_DEPTH));
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic                  gen_call_q;
    logic                  start_q;
    logic                  stop_q;
    logic                  activity_q;
    logic                  rx_done_q;
    logic                  tx_abrt_q;
    logic                  rd_req_q;
    logic                  tx_empty_q;
    logic                  tx_over_q;
    logic                  rx_full_q;
    logic                  rx_over_q;
    logic                  rx_under_q;
    logic [ABRT_W-1:0]     abort_reason_q;
    isl_stat_t             stat_q;
    isl_stat_t             raw;
    logic                  clr_all;
    logic                  disabled;
    logic [BYTE_W-1:0]     buf_mem [BUF_DEPTH];
    logic [BUF_PTR_W-1:0]  wr_ptr_q;
    logic [BUF_PTR_W-1:0]  rd_ptr_q;
    logic [BUF_CNT_W-1:0]  cnt_q;
    logic [BUF_CNT_W-1:0]  cnt_d;
    logic                  arrive;
    logic                  no_room;
    logic                  push;
    logic                  pop;
    logic [LVL_W:0]        rx_total;

    assign clr_all  = CLEAR_RD.combined_interrupt_clear;
    assign disabled = ~ENABLE_INTERNAL;

    // ****************************************
    // bus condition flags
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            gen_call_q <= 1'b0;
            start_q    <= 1'b0;
            stop_q     <= 1'b0;
            activity_q <= 1'b0;
            rx_done_q  <= 1'b0;
        end
        else
        begin
            gen_call_q <= sticky(EVENTS.gen_call_ack,
                                 CLEAR_RD.general_call_clear | clr_all | disabled,
                                 gen_call_q);
            start_q    <= sticky(EVENTS.start,
                                 CLEAR_RD.start_clear | clr_all, start_q);
            stop_q     <= sticky(EVENTS.stop,
                                 CLEAR_RD.stop_clear | clr_all, stop_q);
            activity_q <= sticky(EVENTS.activity,
                                 CLEAR_RD.activity_clear_reg | clr_all | disabled,
                                 activity_q);
            rx_done_q  <= sticky(EVENTS.slv_tx_nack,
                                 CLEAR_RD.rx_done_clear | clr_all, rx_done_q);
        end
    end

    // ****************************************
    // transmit abort and read request
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_abrt_q      <= 1'b0;
            abort_reason_q <= '0;
        end
        else
        begin
            tx_abrt_q <= sticky(EVENTS.tx_abort,
                                CLEAR_RD.abort_clear_reg | clr_all, tx_abrt_q);
            if (EVENTS.tx_abort)
            begin
                abort_reason_q <= ABORT_CAUSE;
            end
        end
    end

    // the bus stays stretched until software acknowledges the request
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rd_req_q <= 1'b0;
        end
        else
        begin
            rd_req_q <= sticky(EVENTS.rd_req,
                               CLEAR_RD.read_request_clear | clr_all, rd_req_q);
        end
    end

    // ****************************************
    // threshold flags
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_empty_q <= 1'b0;
            rx_full_q  <= 1'b0;
        end
        else
        begin
            if (!CTRL_ENABLE)
            begin
                // flushed fifo looks empty, but only matters while engines run
                tx_empty_q <= FSM_ACTIVE;
                rx_full_q  <= 1'b0;
            end
            else
            begin
                // one cycle behind the levels, cheaper than a comb path out
                tx_empty_q <= (TX_LEVEL <= TX_THRESHOLD);
                rx_full_q  <= (RX_LEVEL >= RX_THRESHOLD);
            end
        end
    end

    // ****************************************
    // overflow and underflow flags
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_over_q  <= 1'b0;
            rx_over_q  <= 1'b0;
            rx_under_q <= 1'b0;
        end
        else
        begin
            // a late write in the clear cycle still reports
            tx_over_q  <= sticky(DCMD_WRITE & is_full(TX_LEVEL),
                                 CLEAR_RD.tx_over_clear | clr_all | disabled,
                                 tx_over_q);
            rx_over_q  <= sticky(arrive & no_room,
                                 CLEAR_RD.rx_over_clear | clr_all | disabled,
                                 rx_over_q);
            rx_under_q <= sticky(DCMD_READ & (RX_LEVEL == '0),
                                 CLEAR_RD.rx_under_clear | clr_all | disabled,
                                 rx_under_q);
        end
    end

    // ****************************************
    // receive byte buffer
    // ****************************************

    // bytes in the buffer count toward the fifo so the full test is honest
    assign rx_total      = {1'b0, RX_LEVEL} + (LVL_W+1)'(cnt_q);
    // a dropped byte is still accepted so the bus never stalls on it
    assign no_room       = (rx_total >= (LVL_W+1)'(FIFO_DEPTH));
    assign RX_BYTE_READY = (cnt_q != BUF_CNT_W'(BUF_DEPTH));
    assign arrive        = RX_BYTE_VALID & RX_BYTE_READY;
    // every accepted byte with room is pushed while enabled, general call data included
    assign push          = arrive & ~no_room & CTRL_ENABLE;
    assign pop           = RXF_VALID & RXF_READY;
    assign RXF_VALID     = (cnt_q != '0);

    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = cnt_q + BUF_CNT_W'(1);
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - BUF_CNT_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else if (!CTRL_ENABLE)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + BUF_PTR_W'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + BUF_PTR_W'(1);
            end
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end
        else if (push)
        begin
            buf_mem[wr_ptr_q] <= RX_BYTE_DATA;
        end
    end

    assign RXF_DATA = buf_mem[rd_ptr_q];

    // ****************************************
    // status view
    // ****************************************
    always_comb
    begin
        raw                     = '0;
        raw.general_call_seen   = gen_call_q;
        raw.start_seen          = start_q;
        raw.stop_seen           = stop_q;
        raw.activity            = activity_q;
        raw.rx_done             = rx_done_q;
        raw.transmit_abort_flag = tx_abrt_q;
        raw.rd_req              = rd_req_q;
        raw.tx_empty            = tx_empty_q;
        raw.tx_over             = tx_over_q;
        raw.rx_full             = rx_full_q;
        raw.rx_over             = rx_over_q;
        raw.rx_under            = rx_under_q;
    end

    // no write path exists: the word is only ever derived
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            stat_q <= INTR_STATUS_RESET;
        end
        else
        begin
            // masking after the flags, so a masked event still latches
            stat_q      <= raw & INTR_MASK;
            stat_q.rsvd <= '0;
        end
    end

    assign INTR_STATUS  = stat_q;
    assign RAW_STATUS   = raw;
    assign ABORT_REASON = abort_reason_q;

    // ****************************************
    // fifo and bus side controls
    // ****************************************
    // abort flush outlives the event until software reads the clear
    assign TX_FLUSH     = tx_abrt_q | ~CTRL_ENABLE;
    assign TX_ACCEPT    = ~tx_abrt_q;
    assign RX_FLUSH     = ~CTRL_ENABLE;
    assign SCL_HOLD_LOW = rd_req_q;

endmodule

//--- logic/isl_pkg.sv
package isl_pkg;

    // ****************************************
    // register map and widths
    // ****************************************
    localparam logic [31:0] INTR_STATUS_OFFSET = 32'h5000152c;
    localparam logic [15:0] INTR_STATUS_RESET  = 16'h0000;
    localparam int unsigned STAT_W             = 16;
    localparam int unsigned RSVD_W             = 4;
    localparam int unsigned FIFO_DEPTH         = 32;
    localparam int unsigned LVL_W              = 6;
    localparam int unsigned BYTE_W             = 8;
    localparam int unsigned ABRT_W             = 16;
    localparam int unsigned BUF_DEPTH          = 2;
    localparam int unsigned BUF_CNT_W          = 2;
    localparam int unsigned BUF_PTR_W          = 1;

    // ****************************************
    // status word, bit 15 down to bit 0
    // ****************************************
    typedef struct packed {
        logic [RSVD_W-1:0] rsvd;
        logic              general_call_seen;
        logic              start_seen;
        logic              stop_seen;
        logic              activity;
        logic              rx_done;
        logic              transmit_abort_flag;
        logic              rd_req;
        logic              tx_empty;
        logic              tx_over;
        logic              rx_full;
        logic              rx_over;
        logic              rx_under;
    } isl_stat_t;

    // one-cycle events from the bus engine, activity is a level
    typedef struct packed {
        logic gen_call_ack;
        logic start;
        logic stop;
        logic activity;
        logic slv_tx_nack;
        logic tx_abort;
        logic rd_req;
    } isl_ev_t;

    // one-cycle read strobes of the clear registers
    typedef struct packed {
        logic general_call_clear;
        logic start_clear;
        logic stop_clear;
        logic activity_clear_reg;
        logic rx_done_clear;
        logic abort_clear_reg;
        logic read_request_clear;
        logic tx_over_clear;
        logic rx_over_clear;
        logic rx_under_clear;
        logic combined_interrupt_clear;
    } isl_clr_t;

endpackage

//--- tb/isl_props.sv
`timescale 1ns/10ps
// ****
// status flag properties
// ****
module isl_props
(
    input wire logic                      CORE_CLK,
    input wire logic                      RESET_N,
    input wire isl_pkg::isl_ev_t          EVENTS,
    input wire logic [isl_pkg::ABRT_W-1:0] ABORT_CAUSE,
    input wire isl_pkg::isl_clr_t         CLEAR_RD,
    input wire logic                      CTRL_ENABLE,
    input wire logic                      ENABLE_INTERNAL,
    input wire logic [isl_pkg::LVL_W-1:0] TX_LEVEL,
    input wire logic [isl_pkg::LVL_W-1:0] TX_THRESHOLD,
    input wire logic [isl_pkg::LVL_W-1:0] RX_LEVEL,
    input wire logic [isl_pkg::LVL_W-1:0] RX_THRESHOLD,
    input wire isl_pkg::isl_stat_t        INTR_MASK,
    input wire isl_pkg::isl_stat_t        INTR_STATUS,
    input wire isl_pkg::isl_stat_t        RAW_STATUS,
    input wire logic [isl_pkg::ABRT_W-1:0] ABORT_REASON,
    input wire logic                      TX_FLUSH,
    input wire logic                      TX_ACCEPT,
    input wire logic                      RX_FLUSH,
    input wire logic                      SCL_HOLD_LOW
);
    import isl_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    property p_bus;
        (EVENTS.start |=> RAW_STATUS.start_seen) and (EVENTS.stop |=> RAW_STATUS.stop_seen);
    endproperty
    property p_mask;
        INTR_STATUS == ($past(RAW_STATUS) & $past(INTR_MASK));
    endproperty
    property p_abort;
        EVENTS.tx_abort |=> RAW_STATUS.transmit_abort_flag && TX_FLUSH && !TX_ACCEPT
            && ABORT_REASON == $past(ABORT_CAUSE);
    endproperty
    property p_rdreq;
        EVENTS.rd_req |=> SCL_HOLD_LOW && RAW_STATUS.rd_req;
    endproperty
    property p_rdclr;
        CLEAR_RD.read_request_clear && !EVENTS.rd_req |=> !SCL_HOLD_LOW;
    endproperty
    property p_txe;
        CTRL_ENABLE |=> RAW_STATUS.tx_empty == ($past(TX_LEVEL) <= $past(TX_THRESHOLD));
    endproperty
    property p_rxf;
        CTRL_ENABLE |=> RAW_STATUS.rx_full == ($past(RX_LEVEL) >= $past(RX_THRESHOLD));
    endproperty
    property p_off;
        !CTRL_ENABLE |-> TX_FLUSH && RX_FLUSH ##1 !RAW_STATUS.rx_full;
    endproperty
    property p_act;
        RAW_STATUS.activity && ENABLE_INTERNAL && !CLEAR_RD.activity_clear_reg
            && !CLEAR_RD.combined_interrupt_clear |=> RAW_STATUS.activity;
    endproperty
    property p_gen;
        !ENABLE_INTERNAL && !EVENTS.gen_call_ack |=> !RAW_STATUS.general_call_seen;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus condition flag missing");
    a_mask: assert property (p_mask)
        else $error("masked status wrong");
    a_abort: assert property (p_abort)
        else $error("abort handling wrong");
    a_rdreq: assert property (p_rdreq)
        else $error("read request not held");
    a_rdclr: assert property (p_rdclr)
        else $error("read request not cleared");
    a_txe: assert property (p_txe)
        else $error("tx low-water wrong");
    a_rxf: assert property (p_rxf)
        else $error("rx high-water wrong");
    a_off: assert property (p_off)
        else $error("disable handling wrong");
    a_act: assert property (p_act)
        else $error("activity lost");
    a_gen: assert property (p_gen)
        else $error("general call not cleared");
    c_abort: cover property (EVENTS.tx_abort);
    c_rdclr: cover property (CLEAR_RD.read_request_clear && SCL_HOLD_LOW);
    c_off: cover property (!CTRL_ENABLE && ENABLE_INTERNAL);
endmodule

//--- tb/isl_rxf_sink.sv
`timescale 1ns/10ps
// ****
// receive fifo stand-in
// ****
module isl_rxf_sink
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        valid,
    input  wire logic [7:0]  data,
    input  wire logic        stall,
    output      logic        ready,
    output      logic [15:0] seen,
    output      logic [3:0]  count
);
    // stalling backs the two-entry buffer up so its refusal shows
    assign ready = !stall;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen <= 16'h0000;
            count <= 4'h0;
        end
        else if (valid && ready)
        begin
            seen <= {seen[7:0], data};
            count <= count + 4'h1;
        end
    end
endmodule

//--- tb/test_i2c_interrupt_status_logic.sv
`timescale 1ns/10ps
// ****
// stimulus and checks
// ****
module test_i2c_interrupt_status_logic;
    import isl_pkg::*;
    logic              clk, rst_n, en, ien, fsm, dw, dr, bv, stall;
    logic              brdy, fv, frdy, fl_t, acc, fl_r, hold;
    isl_ev_t           ev;
    isl_clr_t          clr;
    isl_stat_t         mask, st, raw;
    logic [ABRT_W-1:0] cause, why;
    logic [LVL_W-1:0]  txl, txt, rxl, rxt;
    logic [BYTE_W-1:0] bd, fd;
    logic [15:0]       seen;
    logic [3:0]        n_rx;
    int                failures, total_checks, i, l;
    int                evb[6] = '{6, 5, 4, 2, 1, 0};
    isl_intr_status uut (.CORE_CLK(clk), .RESET_N(rst_n), .EVENTS(ev), .ABORT_CAUSE(cause),
        .CLEAR_RD(clr), .CTRL_ENABLE(en), .ENABLE_INTERNAL(ien), .FSM_ACTIVE(fsm),
        .TX_LEVEL(txl), .TX_THRESHOLD(txt), .RX_LEVEL(rxl), .RX_THRESHOLD(rxt),
        .DCMD_WRITE(dw), .DCMD_READ(dr), .INTR_MASK(mask), .RX_BYTE_VALID(bv),
        .RX_BYTE_READY(brdy), .RX_BYTE_DATA(bd), .RXF_VALID(fv), .RXF_READY(frdy),
        .RXF_DATA(fd), .INTR_STATUS(st), .RAW_STATUS(raw), .ABORT_REASON(why),
        .TX_FLUSH(fl_t), .TX_ACCEPT(acc), .RX_FLUSH(fl_r), .SCL_HOLD_LOW(hold));
    isl_rxf_sink sink (.clk(clk), .rst_n(rst_n), .valid(fv), .data(fd), .stall(stall),
        .ready(frdy), .seen(seen), .count(n_rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic send(input logic [7:0] d);
        int n;
        bv = 1;
        bd = d;
        n = 0;
        while (brdy !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        if (brdy !== 1'b1)
        begin
            failures++;
            tally_and_finish();
        end
        // valid stays up so back-to-back bytes need no idle cycle
        tick(1);
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {ev, clr, en, ien, fsm, dw, dr, bv, bd, stall, cause, rst_n} = '0;
        {txl, txt, rxl, rxt} = {6'h05, 6'h02, 6'h00, 6'h04};
        mask = 16'hffff;
        tick(2);
        rst_n = 1;
        chk(st | raw | why, 16'h0000);
        {en, ien} = 2'b11;
        tick(2);
        foreach (evb[k])
        begin
            i = evb[k];
            ev = 7'h01 << i;
            cause = 16'h0c00 + 16'(i);
            tick(1);
            ev = '0;
            chk(raw, 16'h0001 << (i + 5));
            if (i == 1)
                chk({why, fl_t, acc}, {16'h0c01, 2'b10});
            if (i == 0)
                chk(hold, 1'b1);
            tick(1);
            chk(st, 16'h0001 << (i + 5));
            tick(3);
            chk({raw, acc}, {16'h0001 << (i + 5), i != 1});
            clr = 11'h001 << (i + 4);
            tick(1);
            clr = '0;
            chk({raw, hold, acc}, 18'h00001);
        end
        mask = ~16'h0400;
        ev.start = 1;
        tick(1);
        ev = '0;
        tick(1);
        chk({raw, st}, {16'h0400, 16'h0000});
        {ev.activity, ev.gen_call_ack, clr.combined_interrupt_clear} = 3'b111;
        tick(1);
        {ev, clr} = '0;
        tick(4);
        chk(raw, 16'h0900);
        ien = 0;
        tick(1);
        chk(raw, 16'h0000);
        {ien, txt, rxt} = {1'b1, 6'h04, 6'h04};
        for (l = 3; l < 6; l++)
        begin
            {txl, rxl} = {6'(l), 6'(l)};
            tick(2);
            chk({raw.tx_empty, raw.rx_full}, {l <= 4, l >= 4});
        end
        {txl, txt, rxl, rxt, dw} = {6'h1f, 6'h04, 6'h00, 6'h00, 1'b1};
        tick(1);
        {txl, dr} = {6'h20, 1'b1};
        tick(1);
        {dw, dr} = 2'b00;
        tick(1);
        chk(raw, 16'h000d);
        {en, fsm} = 2'b01;
        tick(2);
        chk({raw, fl_t, fl_r}, {16'h0019, 2'b11});
        {ien, fsm} = 2'b00;
        tick(2);
        chk(raw, 16'h0000);
        {en, ien, txl, txt, rxt, stall} = {2'b11, 6'h05, 6'h02, 6'h04, 1'b1};
        tick(1);
        send(8'h3c);
        send(8'hc3);
        {bv, bd} = {1'b1, 8'h55};
        tick(2);
        chk(brdy, 1'b0);
        {bv, stall} = 2'b00;
        tick(3);
        chk({seen, n_rx}, {16'h3cc3, 4'h2});
        rxl = 6'h20;
        send(8'h99);
        bv = 0;
        tick(2);
        chk({raw.rx_over, n_rx}, {1'b1, 4'h2});
        tally_and_finish();
    end
endmodule
bind isl_intr_status isl_props u_props (
    .CORE_CLK        (CORE_CLK),
    .RESET_N         (RESET_N),
    .EVENTS          (EVENTS),
    .ABORT_CAUSE     (ABORT_CAUSE),
    .CLEAR_RD        (CLEAR_RD),
    .CTRL_ENABLE     (CTRL_ENABLE),
    .ENABLE_INTERNAL (ENABLE_INTERNAL),
    .TX_LEVEL        (TX_LEVEL),
    .TX_THRESHOLD    (TX_THRESHOLD),
    .RX_LEVEL        (RX_LEVEL),
    .RX_THRESHOLD    (RX_THRESHOLD),
    .INTR_MASK       (INTR_MASK),
    .INTR_STATUS     (INTR_STATUS),
    .RAW_STATUS      (RAW_STATUS),
    .ABORT_REASON    (ABORT_REASON),
    .TX_FLUSH        (TX_FLUSH),
    .TX_ACCEPT       (TX_ACCEPT),
    .RX_FLUSH        (RX_FLUSH),
    .SCL_HOLD_LOW    (SCL_HOLD_LOW)
);
